// file: inc/host_link_pkg.sv
// Constants for the device-side asynchronous host command link.
// Assumes a single 125 MHz clock and a synchronous active-high reset.
package host_link_pkg;
	localparam int CLK_HZ = 125000000;
	localparam int CLK_NS = 8;
	// Timing figures as printed, in their own units
	localparam int TX_RELEASE_US = 10;
	localparam int WAKE_IGNORE_US = 1500;
	localparam int READY_LOW_MIN_US = 1;
	localparam int READY_DELAY_US = 20;
	localparam int RESP_FAST_US = 1000;
	localparam int RESP_SLOW_US = 20000;
	localparam int DEBUG_ADD_US = 15000;
	localparam int BYTE_TIMEOUT_US = 110000;
	// Cycle counts, then baud limits and sizes
	localparam int TX_RELEASE_CYC = TX_RELEASE_US * 1000 / CLK_NS;
	localparam int WAKE_IGNORE_CYC = WAKE_IGNORE_US * 1000 / CLK_NS;
	localparam int READY_LOW_CYC = (READY_LOW_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int READY_DELAY_CYC = READY_DELAY_US * 1000 / CLK_NS;
	localparam int RESP_FAST_CYC = RESP_FAST_US * 1000 / CLK_NS;
	localparam int RESP_SLOW_CYC = RESP_SLOW_US * 1000 / CLK_NS;
	localparam int DEBUG_ADD_CYC = DEBUG_ADD_US * 1000 / CLK_NS;
	localparam int BYTE_TIMEOUT_CYC = BYTE_TIMEOUT_US * 1000 / CLK_NS;
	localparam int BAUD_MIN = 9600;
	localparam int BAUD_MAX = 115200;
	localparam int BAUD_DEFAULT = 9600;
	localparam int DATA_BITS = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int CNT_W = 24;
endpackage

// file: design/host_link.sv
// Device-side asynchronous host command link: 8N1 receiver and transmitter,
// open-drain ready handshake, wake input, timeouts and a response FIFO.
// Assumes command logic outside feeds response bytes and reads command bytes.
// Functional notes
// - Any activity on the receive pin selects asynchronous mode immediately.
// - Baud rate comes from setup input, latched once, on the first edge after reset release.
// - Transmit is driven only while sending, released within 10 us after stop.
// - Transmit idles released on pull-up, driven push-pull during each character.
// - Incoming bytes are discarded for about 1.5 ms from the falling edge of a wake pulse.
// - Characters are one start, eight data, no parity, one stop bit.
// - Ready line is wire-AND; either side pulls low to hold the other.
// - Device pulls ready low within 100 us after the stop bit of an accepted byte.
// - A byte counts as received at stop bit detection.
// - Device waits for ready high before starting any transmission.
// - Responses go out unprompted in async mode, gated by ready high and no own ready pull pending or held.
// - Response start within 1 ms, slow commands 20 ms, plus 15 ms debug; resp_cnt counts to this limit but nothing acts on it.
// - Gap over 110 ms between bytes abandons the command silently.
// - Synchronous mode uses the same 110 ms per-byte limit.
// - Multi-byte values travel least significant byte first.
// - Commands during intermediate response bytes are ignored.
// - Ready pulled low after each accepted byte for at least 1 us.
`timescale 1ns/1ps

module resp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wp_r;
	logic [AW:0] rp_r;
	logic full;
	logic empty;
	assign empty = (wp_r == rp_r);
	assign full = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rp_r[AW-1:0]];
	always_ff @(posedge clk) begin
		if (rst) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			if (in_valid && !full) begin
				mem[wp_r[AW-1:0]] <= in_data;
				wp_r <= wp_r + 1'b1;
			end
			if (out_ready && !empty)
				rp_r <= rp_r + 1'b1;
		end
	end
endmodule

module host_link import host_link_pkg::*; #(
	parameter int CLK_FREQ = CLK_HZ,
	parameter int WAKE_CYC = WAKE_IGNORE_CYC,
	parameter int TIMEOUT_CYC = BYTE_TIMEOUT_CYC,
	parameter int FAST_CYC = RESP_FAST_CYC,
	parameter int SLOW_CYC = RESP_SLOW_CYC,
	parameter int DEBUG_CYC = DEBUG_ADD_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [17:0] baud_rate_setup,
	input wire logic debug_timing_setup,
	input wire logic rx_pin,
	output logic tx_out,
	output logic tx_oe,
	input wire logic ready_handshake_line_in,
	output logic ready_handshake_line_out,
	output logic ready_handshake_line_oe,
	input wire logic wake_sync_input,
	output logic uart_mode,
	output logic cmd_valid,
	output logic [7:0] cmd_data,
	input wire logic cmd_busy,
	input wire logic cmd_slow,
	input wire logic resp_valid,
	output logic resp_ready,
	input wire logic [7:0] resp_data,
	input wire logic resp_last,
	output logic cmd_abort
);
	typedef enum logic [3:0] {
		TX_IDLE = 4'h1,
		TX_WAIT = 4'h2,
		TX_SEND = 4'h4,
		TX_HOLD = 4'h8
	} tx_state_t;

	typedef struct packed {
		logic [1:0] rx_sync;
		logic [1:0] rdy_sync;
		logic [1:0] wake_sync;
		logic wake_prev;
		logic [15:0] bit_cyc;
		logic uart_mode;
		logic rx_busy;
		logic [15:0] rx_cnt;
		logic [3:0] rx_bit;
		logic [7:0] rx_shift;
		logic cmd_valid;
		logic [7:0] cmd_data;
		logic [CNT_W-1:0] wake_cnt;
		logic [CNT_W-1:0] gap_cnt;
		logic in_cmd;
		logic cmd_abort;
		logic [15:0] rdy_dly;
		logic [7:0] rdy_low;
		logic rdy_pull;
		logic rdy_pend;
		tx_state_t tx_st;
		logic [15:0] tx_cnt;
		logic [3:0] tx_bit;
		logic [9:0] tx_shift;
		logic tx_out;
		logic tx_oe;
		logic [CNT_W-1:0] resp_cnt;
		logic [CNT_W-1:0] resp_lim;
		logic resp_pend;
		logic resp_taken;
		logic resp_last;
	} state_t;

	state_t st_r;
	state_t st_nxt;
	logic fifo_in_ready;
	logic fifo_valid;
	logic [7:0] fifo_data;
	logic fifo_pop;
	logic [8:0] fifo_word;
	logic [8:0] fifo_out;
	logic baud_loaded_r;
	logic [15:0] baud_div_r;
	logic [15:0] rdy_wait_r;

	function automatic logic [15:0] div_cycles(input logic [17:0] baud);
		logic [31:0] b;
		b = {14'h0000, baud};
		if (b < BAUD_MIN)
			b = BAUD_MIN;
		if (b > BAUD_MAX)
			b = BAUD_MAX;
		return 16'(CLK_FREQ / b);
	endfunction

	assign fifo_word = {resp_last, resp_data};
	assign fifo_data = fifo_out[7:0];

	resp_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst(rst),
		.in_valid(resp_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_word),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out)
	);

	assign resp_ready = fifo_in_ready;

	always_comb begin
		st_nxt = st_r;
		fifo_pop = 1'b0;
		st_nxt.cmd_valid = 1'b0;
		st_nxt.cmd_abort = 1'b0;
		st_nxt.rx_sync = {st_r.rx_sync[0], rx_pin};
		st_nxt.rdy_sync = {st_r.rdy_sync[0], ready_handshake_line_in};
		st_nxt.wake_sync = {st_r.wake_sync[0], wake_sync_input};
		st_nxt.wake_prev = st_r.wake_sync[1];
		st_nxt.bit_cyc = baud_div_r;

		// ------------------------------------------------------------
		// Wake blanking
		// ------------------------------------------------------------
		// blank after wake
		if (st_r.wake_prev && !st_r.wake_sync[1])
			st_nxt.wake_cnt = CNT_W'(WAKE_CYC);
		else if (st_r.wake_cnt != '0)
			st_nxt.wake_cnt = st_r.wake_cnt - 1'b1;

		// ------------------------------------------------------------
		// Receiver
		// ------------------------------------------------------------
		if (!st_r.rx_busy) begin
			if (!st_r.rx_sync[1]) begin
				st_nxt.uart_mode = 1'b1;
				st_nxt.rx_busy = 1'b1;
				st_nxt.rx_cnt = st_r.bit_cyc >> 1;
				st_nxt.rx_bit = 4'h0;
			end
		end else if (st_r.rx_cnt != 16'h0000) begin
			st_nxt.rx_cnt = st_r.rx_cnt - 1'b1;
		end else begin
			st_nxt.rx_cnt = st_r.bit_cyc - 1'b1;
			st_nxt.rx_bit = st_r.rx_bit + 1'b1;
			if (st_r.rx_bit == 4'h0 && st_r.rx_sync[1]) begin
				st_nxt.rx_busy = 1'b0;
			end else if (st_r.rx_bit >= 4'h1 && st_r.rx_bit <= 4'(DATA_BITS)) begin
				st_nxt.rx_shift = {st_r.rx_sync[1], st_r.rx_shift[7:1]};
			end else if (st_r.rx_bit == 4'(DATA_BITS + 1)) begin
				st_nxt.rx_busy = 1'b0;
				if (st_r.rx_sync[1] && st_r.wake_cnt == '0 && !st_r.resp_pend && !st_r.resp_taken) begin
					st_nxt.cmd_valid = 1'b1;
					st_nxt.cmd_data = st_r.rx_shift;
					st_nxt.in_cmd = 1'b1;
					st_nxt.gap_cnt = '0;
					st_nxt.rdy_pend = 1'b1;
					st_nxt.rdy_dly = 16'(READY_DELAY_CYC);
					st_nxt.resp_pend = 1'b1;
					st_nxt.resp_cnt = '0;
					st_nxt.resp_lim = CNT_W'(cmd_slow ? SLOW_CYC : FAST_CYC)
						+ (debug_timing_setup ? CNT_W'(DEBUG_CYC) : '0);
				end
			end
		end

		// ------------------------------------------------------------
		// Ready handshake
		// ------------------------------------------------------------
		// delayed pull low
		if (st_r.rdy_pend) begin
			if (st_r.rdy_dly != 16'h0000) begin
				st_nxt.rdy_dly = st_r.rdy_dly - 1'b1;
			end else begin
				st_nxt.rdy_pend = 1'b0;
				st_nxt.rdy_pull = 1'b1;
				st_nxt.rdy_low = 8'(READY_LOW_CYC);
			end
		end else if (st_r.rdy_pull) begin
			if (st_r.rdy_low != 8'h00)
				st_nxt.rdy_low = st_r.rdy_low - 1'b1;
			else if (!cmd_busy)
				st_nxt.rdy_pull = 1'b0;
		end

		// ------------------------------------------------------------
		// Inter-byte timeout
		// ------------------------------------------------------------
		// silent abandon
		if (st_r.in_cmd) begin
			if (st_r.gap_cnt >= CNT_W'(TIMEOUT_CYC)) begin
				st_nxt.in_cmd = 1'b0;
				st_nxt.cmd_abort = 1'b1;
				st_nxt.resp_pend = 1'b0;
				st_nxt.resp_taken = 1'b0;
			end else begin
				st_nxt.gap_cnt = st_r.gap_cnt + 1'b1;
			end
		end
		if (st_r.resp_pend && st_r.resp_cnt < st_r.resp_lim)
			st_nxt.resp_cnt = st_r.resp_cnt + 1'b1;

		// ------------------------------------------------------------
		// Transmitter
		// ------------------------------------------------------------
		case (st_r.tx_st)
			TX_IDLE: begin
				st_nxt.tx_oe = 1'b0;
				st_nxt.tx_out = 1'b1;
				if (fifo_valid && st_r.uart_mode)
					st_nxt.tx_st = TX_WAIT;
			end
			TX_WAIT: begin
				if (st_r.rdy_sync[1] && !st_r.rdy_pull && !st_r.rdy_pend && fifo_valid) begin
					fifo_pop = 1'b1;
					st_nxt.resp_last = fifo_out[8];
					st_nxt.resp_taken = 1'b1;
					st_nxt.resp_pend = 1'b0;
					st_nxt.tx_shift = {1'b1, fifo_data, 1'b0};
					st_nxt.tx_bit = 4'h0;
					st_nxt.tx_cnt = st_r.bit_cyc - 1'b1;
					st_nxt.tx_oe = 1'b1;
					st_nxt.tx_out = 1'b0;
					st_nxt.tx_st = TX_SEND;
				end
			end
			TX_SEND: begin
				if (st_r.tx_cnt != 16'h0000) begin
					st_nxt.tx_cnt = st_r.tx_cnt - 1'b1;
				end else if (st_r.tx_bit == 4'(DATA_BITS + 1)) begin
					st_nxt.tx_cnt = 16'(TX_RELEASE_CYC / 2);
					st_nxt.tx_st = TX_HOLD;
					st_nxt.gap_cnt = '0;
				end else begin
					st_nxt.tx_bit = st_r.tx_bit + 1'b1;
					st_nxt.tx_cnt = st_r.bit_cyc - 1'b1;
					st_nxt.tx_shift = {1'b1, st_r.tx_shift[9:1]};
					st_nxt.tx_out = st_r.tx_shift[1];
				end
			end
			TX_HOLD: begin
				st_nxt.tx_oe = 1'b0;
				st_nxt.tx_out = 1'b1;
				if (st_r.tx_cnt != 16'h0000) begin
					st_nxt.tx_cnt = st_r.tx_cnt - 1'b1;
				end else begin
					st_nxt.tx_st = TX_IDLE;
					if (st_r.resp_last) begin
						st_nxt.resp_taken = 1'b0;
						st_nxt.in_cmd = 1'b0;
					end
				end
			end
			default: st_nxt.tx_st = TX_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= '0;
			st_r.rx_sync <= 2'h3;
			st_r.rdy_sync <= 2'h3;
			st_r.wake_sync <= 2'h3;
			st_r.wake_prev <= 1'b1;
			st_r.tx_st <= TX_IDLE;
			st_r.tx_out <= 1'b1;
			st_r.tx_shift <= 10'h3FF;
			st_r.bit_cyc <= 16'(CLK_FREQ / BAUD_DEFAULT);
		end else begin
			st_r <= st_nxt;
		end
	end

	// Baud divisor is caught once, on the first edge after reset release
	always_ff @(posedge clk) begin
		if (rst) begin
			baud_loaded_r <= 1'b0;
			baud_div_r <= 16'(CLK_FREQ / BAUD_DEFAULT);
		end else if (!baud_loaded_r) begin
			baud_loaded_r <= 1'b1;
			baud_div_r <= div_cycles(baud_rate_setup);
		end
	end

	// Cycles from a received byte until the device pulls ready; saturates
	always_ff @(posedge clk) begin
		if (rst)
			rdy_wait_r <= 16'h0000;
		else if (cmd_valid)
			rdy_wait_r <= 16'h0001;
		else if (ready_handshake_line_oe)
			rdy_wait_r <= 16'h0000;
		else if (rdy_wait_r != 16'h0000 && rdy_wait_r != 16'hFFFF)
			rdy_wait_r <= rdy_wait_r + 1'b1;
	end

	assign tx_out = st_r.tx_out;
	assign tx_oe = st_r.tx_oe;
	assign ready_handshake_line_out = 1'b0;
	assign ready_handshake_line_oe = st_r.rdy_pull;
	assign uart_mode = st_r.uart_mode;
	assign cmd_valid = st_r.cmd_valid;
	assign cmd_data = st_r.cmd_data;
	assign cmd_abort = st_r.cmd_abort;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	tx_idle_release_a: assert property (@(posedge clk) disable iff (rst)
		(st_r.tx_st == TX_IDLE) |-> !tx_oe) else $error("tx driven while idle");
	tx_start_gate_a: assert property (@(posedge clk) disable iff (rst)
		$rose(tx_oe) |-> $past(st_r.rdy_sync[1])) else $error("tx started while ready low");
	start_bit_low_a: assert property (@(posedge clk) disable iff (rst)
		$rose(tx_oe) |-> !tx_out) else $error("start bit not low");
	rdy_low_min_a: assert property (@(posedge clk) disable iff (rst)
		$rose(ready_handshake_line_oe) |-> ready_handshake_line_oe [*8]) else $error("ready low too short");
	sequence stop_seen_s;
		$rose(cmd_valid);
	endsequence
	rdy_follow_a: assert property (@(posedge clk) disable iff (rst)
		(rdy_wait_r != 16'h0000) |-> (rdy_wait_r <= 16'(5 * READY_DELAY_CYC))) else $error("ready not pulled after byte");
	rdy_arm_a: assert property (@(posedge clk) disable iff (rst)
		stop_seen_s |=> (rdy_wait_r == 16'h0001)) else $error("ready wait not started");
	wake_blank_a: assert property (@(posedge clk) disable iff (rst)
		(st_r.wake_cnt != '0) |-> !cmd_valid) else $error("byte accepted during wake blank");
	mode_sel_a: assert property (@(posedge clk) disable iff (rst)
		(!st_r.rx_sync[1] && !st_r.rx_busy) |=> uart_mode) else $error("mode not selected");
	baud_hold_a: assert property (@(posedge clk) disable iff (rst)
		$past(baud_loaded_r) |-> $stable(baud_div_r)) else $error("baud changed without reset");
	abort_clear_a: assert property (@(posedge clk) disable iff (rst)
		cmd_abort |-> !st_r.in_cmd) else $error("command kept after timeout");
endmodule

// file: tb/host_model.sv
// Host-side partner: sends 8N1 commands on rx, receives the device's tx bytes,
// and clamps the shared ready line. Assumes the bench resolves both wires.
`timescale 1ns/1ps

module host_model #(
	parameter int BIT_CYC = 16,
	parameter int GAP_CYC = 12500
) (
	input wire logic clk,
	input wire logic tx_wire,
	input wire logic ready_wire,
	output logic rx_pin,
	output logic host_pull,
	output logic [7:0] rx_byte,
	output logic rx_stb
);
	int now_cyc = 0;
	int last_end = -GAP_CYC;

	initial begin
		rx_pin = 1'b1;
		host_pull = 1'b0;
		rx_stb = 1'b0;
		rx_byte = 8'h00;
	end

	always @(posedge clk) now_cyc <= now_cyc + 1;

	task automatic send_byte(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		while (now_cyc - last_end < GAP_CYC || ready_wire !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		for (int i = 0; i < 10; i++) begin
			rx_pin = fr[i];
			repeat (BIT_CYC) @(posedge clk);
			#1;
		end
		last_end = now_cyc;
	endtask

	task automatic set_pull(input logic p);
		host_pull = p;
	endtask

	// mid-bit sampling, stop must be high
	always begin
		@(negedge tx_wire);
		repeat (BIT_CYC / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge clk);
			rx_byte[i] = tx_wire;
		end
		repeat (BIT_CYC) @(posedge clk);
		#1;
		rx_stb = tx_wire;
		@(posedge clk);
		#1;
		rx_stb = 1'b0;
	end
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the host link: commands, held and drained
// responses, wake blanking and the byte timeout. Clock 125 MHz.
`timescale 1ns/1ps

module tb_top;
	import host_link_pkg::*;
	localparam int BIT = 16;
	localparam int TMO = 8000;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [17:0] baud = 18'h1C200;
	logic dbg = 1'b0;
	logic wake = 1'b1;
	logic busy = 1'b0;
	logic slow = 1'b0;
	logic rvalid = 1'b0;
	logic rlast = 1'b0;
	logic [7:0] rdata = 8'h00;
	logic tx_out, tx_oe, rdy_out, rdy_oe, mode, cvalid, rready, abort, rx_pin, host_pull, hstb;
	logic [7:0] cdata, hbyte;
	// Pull-ups on both shared wires; ready is wire-AND
	wire logic tx_wire = tx_oe ? tx_out : 1'b1;
	wire logic ready_wire = (rdy_oe ? rdy_out : 1'b1) & ~host_pull;
	logic [7:0] exp_cmd[$];
	logic [7:0] exp_tx[$];
	logic [31:0] seed = 32'h00014165;
	int n_fail = 0;
	int check_count = 0;
	int cyc = 0;
	int n_abort = 0;
	int oe_run = 0;
	int n;

	always #4 clk = ~clk;

	// Short bit time and timeouts keep the run within budget
	host_link #(.CLK_FREQ(1843200), .WAKE_CYC(3000), .TIMEOUT_CYC(TMO))
		u_dut (.clk(clk), .rst(rst), .baud_rate_setup(baud), .debug_timing_setup(dbg),
		.rx_pin(rx_pin), .tx_out(tx_out), .tx_oe(tx_oe), .ready_handshake_line_in(ready_wire),
		.ready_handshake_line_out(rdy_out), .ready_handshake_line_oe(rdy_oe), .wake_sync_input(wake),
		.uart_mode(mode), .cmd_valid(cvalid), .cmd_data(cdata), .cmd_busy(busy), .cmd_slow(slow),
		.resp_valid(rvalid), .resp_ready(rready), .resp_data(rdata), .resp_last(rlast), .cmd_abort(abort));

	host_model #(.BIT_CYC(BIT), .GAP_CYC(2700)) u_host (.clk(clk), .tx_wire(tx_wire), .ready_wire(ready_wire),
		.rx_pin(rx_pin), .host_pull(host_pull), .rx_byte(hbyte), .rx_stb(hstb));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic tick();
		@(posedge clk);
		#1;
	endtask

	task automatic chk(input logic [31:0] v, input logic [31:0] e);
		check_count++;
		if (v !== e) begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, v, e);
		end
	endtask

	// Valid held until ready is sampled high
	task automatic push(input logic [7:0] d, input logic last);
		rvalid = 1'b1;
		rdata = d;
		rlast = last;
		@(posedge clk);
		while (rready !== 1'b1) @(posedge clk);
		#1;
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ----------------------------------------
	// Scoreboard and wire watch
	// ----------------------------------------
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			n_fail++;
			report_and_stop();
		end
		if (abort === 1'b1) n_abort++;
		if (cvalid === 1'b1) begin
			if (exp_cmd.size() == 0) chk(32'h1, 32'h0);
			else chk(cdata, exp_cmd.pop_front());
		end
		if (hstb === 1'b1) begin
			if (exp_tx.size() == 0) chk(32'h1, 32'h0);
			else chk(hbyte, exp_tx.pop_front());
		end
		if (tx_oe !== 1'b1 && oe_run != 0) chk(oe_run <= 10 * BIT + TX_RELEASE_CYC, 1'b1);
		oe_run = (tx_oe === 1'b1) ? oe_run + 1 : 0;
		if (oe_run == 1) chk(host_pull, 1'b0);
		if (oe_run == 1) chk(tx_wire, 1'b0);
	end

	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	initial begin
		logic [31:0] r;
		int a;
		repeat (5) tick();
		rst = 1'b0;
		repeat (3) tick();
		chk(tx_oe, 1'b0);
		chk(rdy_oe, 1'b0);
		chk(mode, 1'b0);
		$display("test reset done");
		for (int i = 0; i < 3; i++) begin
			r = rnd();
			slow = r[8];
			dbg = r[9];
			busy = (i == 0);
			exp_cmd.push_back(r[7:0]);
			u_host.send_byte(r[7:0]);
			chk(mode, 1'b1);
			n = 0;
			while (rdy_oe !== 1'b1 && n < 12500) begin
				tick();
				n++;
			end
			chk(n < 12500, 1'b1);
			if (i == 0) begin
				repeat (3000) tick();
				chk(rdy_oe, 1'b1);
				busy = 1'b0;
			end
			// Each command is answered before the next one is accepted
			exp_tx.push_back(r[23:16]);
			push(r[23:16], 1'b1);
			rvalid = 1'b0;
			n = 0;
			while (exp_tx.size() != 0 && n < 12500) begin
				tick();
				n++;
			end
			chk(exp_tx.size(), 0);
			repeat (700) tick();
		end
		$display("test commands done");
		u_host.set_pull(1'b1);
		for (int k = 0; k < FIFO_DEPTH; k++) begin
			r = rnd();
			exp_tx.push_back(r[7:0]);
			push(r[7:0], k == FIFO_DEPTH - 1);
		end
		rvalid = 1'b0;
		tick();
		chk(rready, 1'b0);
		repeat (200) tick();
		chk(tx_oe, 1'b0);
		u_host.set_pull(1'b0);
		n = 0;
		while (exp_tx.size() != 0 && n < 30000) begin
			tick();
			n++;
		end
		chk(exp_tx.size(), 0);
		repeat (700) tick();
		chk(tx_oe, 1'b0);
		$display("test responses done");
		wake = 1'b0;
		repeat (1100) tick();
		wake = 1'b1;
		u_host.send_byte(8'hFF);
		repeat (2000) tick();
		exp_cmd.push_back(8'h0F);
		u_host.send_byte(8'h0F);
		repeat (40) tick();
		chk(exp_cmd.size(), 0);
		$display("test wake done");
		a = n_abort;
		n = 0;
		while (n_abort == a && n < TMO + 500) begin
			tick();
			n++;
		end
		chk(n_abort - a, 1);
		chk(n >= TMO - 200, 1'b1);
		$display("test timeout done");
		report_and_stop();
	end
endmodule
